/* File: rtl/eqr_event_queue_recorder.sv */
// Purpose: turns event records into circular event queue writes and publishes them
// Assumes: single clock, memory port reports visibility or external abort per write
// Notes:   one write in flight; producer index moves only on visibility
`timescale 1ns/1ps
module eqr_event_queue_recorder
   import eqr_pkg::*;
#(
   parameter int IDX_W = 19
) (
   input  wire  logic                     clk,
   input  wire  logic                     reset,
   input  wire  logic                     ce,
   input  wire  logic                     psel,
   input  wire  logic                     penable,
   input  wire  logic                     pwrite,
   input  wire  logic [eqr_pkg::ADDR_W-1:0] paddr,
   input  wire  logic [31:0]              pwdata,
   output logic                           pready,
   output logic [31:0]                    prdata,
   output logic                           pslverr,
   input  wire  logic                     ev_valid,
   input  wire  eqr_pkg::eqr_rec_t        ev_rec,
   output logic                           ev_ready,
   output logic                           mem_req_valid,
   input  wire  logic                     mem_req_ready,
   output logic [eqr_pkg::PTR_W-1:0]      mem_req_index,
   output eqr_pkg::eqr_rec_t              mem_req_rec,
   input  wire  logic                     mem_done,
   input  wire  logic                     mem_abort
);
   import eqr_pkg::*;

   localparam logic [PTR_W-1:0] ONE = 20'h00001;

   function automatic logic [PTR_W-1:0] idx_mask(input logic [LOG2_W-1:0] l2);
      return (ONE << l2) - ONE;
   endfunction

   function automatic logic q_full(input logic [PTR_W-1:0] p, input logic [PTR_W-1:0] c,
                                   input logic [LOG2_W-1:0] l2);
      logic [PTR_W-1:0] m;
      logic [PTR_W-1:0] w;
      m = idx_mask(l2);
      w = ONE << l2;
      return ((p & m) == (c & m)) && ((p & w) != (c & w));
   endfunction

   function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p,
                                                 input logic [LOG2_W-1:0] l2);
      logic [PTR_W-1:0] m;
      logic [PTR_W-1:0] w;
      m = idx_mask(l2);
      w = ONE << l2;
      if ((p & m) == m)
         return (p & w) ^ w;
      return (p & (m | w)) + ONE;
   endfunction

   logic                 q_en;
   logic [LOG2_W-1:0]    q_l2;
   logic                 gerr;
   logic [PTR_W-1:0]     producer_index_register;
   logic [PTR_W-1:0]     consumer_index_register;
   logic [CNT_W-1:0]     drops;
   logic [CNT_W-1:0]     merges;
   eqr_wstate_t          wstate;
   eqr_rec_t             last_rec;
   logic                 last_ok;
   eqr_rec_t             buf_q [2];
   logic                 buf_wr;
   logic                 buf_rd;
   logic [1:0]           buf_cnt;

   eqr_rec_t             head;
   logic                 push;
   logic                 pop;
   logic                 writable;
   logic                 full;
   logic                 merge_ok;
   logic                 commit;
   logic                 drop;
   logic [1:0]           next_cnt;
   logic                 wr_req;
   logic                 rd_req;
   logic                 bad_addr;
   logic                 gerr_clr;
   logic [31:0]          rd_data;
   logic [LOG2_W-1:0]    l2_in;
   logic                 eng_idle;
   logic                 have_head;
   logic                 acc_req;
   logic                 ctrl_wr;
   logic                 consumer_index_register_wr;
   logic                 gerr_set;
   logic                 merge_hit;

   assign head      = buf_q[buf_rd];
   assign push      = ev_valid && ev_ready;
   assign full      = q_full(producer_index_register, consumer_index_register, q_l2);
   assign eng_idle  = (wstate == W_IDLE);
   assign have_head = (buf_cnt != 2'd0);
   // idle engine means nothing committed but unpublished
   assign writable  = q_en && !gerr && !full && eng_idle;
   assign merge_ok = last_ok && head.merge_en && !head.stall && !last_rec.stall
                     && (head == last_rec);
   // fifo head is served in arrival order whatever its kind
   assign commit    = have_head && !merge_ok && writable;
   assign drop      = have_head && !merge_ok && !writable && !head.stall;
   // stale head must never count as a merge
   assign merge_hit = have_head && merge_ok;
   assign pop       = eng_idle && (merge_hit || commit || drop);
   assign next_cnt  = buf_cnt + {1'b0, push} - {1'b0, pop};
   // setup phase answers next cycle, access phase carries the write
   assign rd_req    = psel && !penable;
   assign acc_req   = psel && penable && pready;
   assign wr_req    = acc_req && pwrite;
   assign ctrl_wr   = wr_req && (paddr == OFS_CTRL);
   assign consumer_index_register_wr   = wr_req && (paddr == OFS_CONSUMER_INDEX_REGISTER);
   assign gerr_clr  = wr_req && (paddr == OFS_STATUS) && pwdata[STAT_GERR_BIT];
   // abort only counts while a write is outstanding
   assign gerr_set  = (wstate == W_WAIT) && mem_abort;
   assign l2_in    = (pwdata[CTRL_L2_LSB +: LOG2_W] > LOG2_W'(IDX_W)) ? LOG2_W'(IDX_W)
                                                                   : pwdata[CTRL_L2_LSB +: LOG2_W];

   always_comb begin
      rd_data  = 32'h00000000;
      bad_addr = 1'b0;
      unique case (paddr)
         OFS_CTRL: begin
            rd_data[CTRL_EN_BIT] = q_en;
            rd_data[CTRL_L2_LSB +: LOG2_W] = q_l2;
         end
         OFS_STATUS: begin
            rd_data[STAT_GERR_BIT] = gerr;
            rd_data[STAT_BUSY_BIT] = (wstate != W_IDLE);
            rd_data[STAT_FULL_BIT] = full;
            rd_data[STAT_PEND_LSB +: 2] = buf_cnt;
         end
         OFS_PRODUCER_INDEX_REGISTER:   rd_data[PTR_W-1:0] = producer_index_register;
         OFS_CONSUMER_INDEX_REGISTER:   rd_data[PTR_W-1:0] = consumer_index_register;
         OFS_DROPS:  rd_data[CNT_W-1:0] = drops;
         OFS_MERGES: rd_data[CNT_W-1:0] = merges;
         default:    bad_addr = 1'b1;
      endcase
   end

   // apb slave: one wait-free access phase
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= rd_req;
         pslverr <= rd_req && bad_addr;
         if (rd_req && !pwrite)
            prdata <= rd_data;
      end
   end

   // size is clamped so the wrap bit stays inside the pointer
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q_en <= 1'b0;
         q_l2 <= L2_RESET;
      end else if (ce && ctrl_wr) begin
         q_en <= pwdata[CTRL_EN_BIT];
         q_l2 <= l2_in;
      end
   end

   // consumer index belongs to software; no consistency check
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         consumer_index_register <= PTR_RESET;
      else if (ce && consumer_index_register_wr)
         consumer_index_register <= pwdata[PTR_W-1:0];
   end

   // global error set by an aborted write; set wins over software clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         gerr <= 1'b0;
      else if (ce)
         gerr <= gerr_set || (gerr && !gerr_clr);
   end

   // two-entry record buffer, stall records wait here
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         buf_wr   <= 1'b0;
         buf_rd   <= 1'b0;
         buf_cnt  <= 2'd0;
         ev_ready <= 1'b1;
      end else if (ce) begin
         if (push)
            buf_wr <= !buf_wr;
         if (pop)
            buf_rd <= !buf_rd;
         buf_cnt  <= next_cnt;
         ev_ready <= (next_cnt != 2'd2);
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push)
         buf_q[buf_wr] <= ev_rec;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         drops  <= CNT_RESET;
         merges <= CNT_RESET;
      end else if (ce && eng_idle) begin
         if (drop)
            drops <= drops + 1'b1;
         if (merge_hit)
            merges <= merges + 1'b1;
      end
   end

   // write engine: commit, issue, then wait for visibility or abort
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wstate        <= W_IDLE;
         mem_req_valid <= 1'b0;
         mem_req_index <= PTR_RESET;
         mem_req_rec   <= '0;
      end else if (ce) begin
         unique case (wstate)
            W_IDLE: begin
               if (commit) begin
                  mem_req_valid <= 1'b1;
                  mem_req_index <= producer_index_register;
                  mem_req_rec   <= head;
                  wstate        <= W_ISSUE;
               end
            end
            W_ISSUE: begin
               if (mem_req_ready) begin
                  mem_req_valid <= 1'b0;
                  wstate        <= W_WAIT;
               end
            end
            W_WAIT: begin
               if (mem_done || mem_abort)
                  wstate <= W_IDLE;
            end
            default: begin
               // unused code: withdraw any request and go idle
               mem_req_valid <= 1'b0;
               wstate        <= W_IDLE;
            end
         endcase
      end
   end

   // producer index moves only once the record is visible
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         producer_index_register <= PTR_RESET;
      else if (ce && (wstate == W_WAIT) && mem_done)
         // response to the client is not held for this; sync is elsewhere
         producer_index_register <= next_ptr(producer_index_register, q_l2);
   end

   // last committed record, the only merge candidate
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         last_rec <= '0;
         last_ok  <= 1'b0;
      end else if (ce) begin
         if (commit) begin
            last_rec <= head;
            last_ok  <= 1'b1;
         end else if (gerr_set && !mem_done) begin
            // an aborted record never reached the queue
            last_ok  <= 1'b0;
         end
      end
   end
endmodule

/* File: rtl/eqr_pkg.sv */
// Purpose: shared constants and types of the event queue recorder
// Assumes: APB register access, 32-bit data, one word per register
// Notes:   queue pointers carry the wrap bit just above the index
package eqr_pkg;
   localparam int          PTR_W          = 20;
   localparam int          LOG2_W         = 5;
   localparam int          ADDR_W         = 8;
   localparam int          CNT_W          = 16;
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_STATUS     = 8'h04;
   localparam logic [7:0]  OFS_PRODUCER_INDEX_REGISTER       = 8'h08;
   localparam logic [7:0]  OFS_CONSUMER_INDEX_REGISTER       = 8'h0C;
   localparam logic [7:0]  OFS_DROPS      = 8'h10;
   localparam logic [7:0]  OFS_MERGES     = 8'h14;
   localparam int          CTRL_EN_BIT    = 0;
   localparam int          CTRL_L2_LSB    = 8;
   localparam int          STAT_GERR_BIT  = 0;
   localparam int          STAT_BUSY_BIT  = 1;
   localparam int          STAT_FULL_BIT  = 2;
   localparam int          STAT_PEND_LSB  = 4;
   localparam logic [LOG2_W-1:0] L2_RESET = 5'h00;
   localparam logic [PTR_W-1:0]  PTR_RESET = 20'h00000;
   localparam logic [CNT_W-1:0]  CNT_RESET = 16'h0000;

   typedef struct packed {
      logic        stall;
      logic        merge_en;
      logic [7:0]  kind;
      logic [15:0] stream;
      logic [31:0] info;
   } eqr_rec_t;

   typedef enum logic [1:0] {W_IDLE, W_ISSUE, W_WAIT} eqr_wstate_t;
endpackage

/* File: tb/eqr_mem_model.sv */
// Purpose: memory side of the recorder's write port
// Assumes: one write in flight, random acceptance and latency
// Notes:   aborts only while the bench asks for it
`timescale 1ns/1ps
module eqr_mem_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic mem_req_valid,
   input  wire logic abort_next,
   output logic      mem_req_ready,
   output logic      mem_done,
   output logic      mem_abort
);
   int   seed = 32'hB8D0;
   int   lat;
   logic busy;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         {mem_req_ready, mem_done, mem_abort, busy} <= 4'h0;
         lat <= 0;
      end else begin
         mem_done  <= busy && lat == 0 && !abort_next;
         mem_abort <= busy && lat == 0 && abort_next;
         if (mem_req_valid && mem_req_ready) begin
            busy <= 1'b1;
            lat <= $unsigned($random(seed)) % 4;
            mem_req_ready <= 1'b0;
         end else if (busy) begin
            busy <= lat != 0;
            lat <= lat - 1;
         end else begin
            mem_req_ready <= 1'($random(seed));
         end
      end
   end
endmodule

/* File: tb/eqr_chk.sv */
// Purpose: port checks of the event queue recorder
// Assumes: ce held high
// Notes:   bound to the recorder top module
`timescale 1ns/1ps
module eqr_chk
   import eqr_pkg::*;
(
   input wire logic                         clk,
   input wire logic                         reset,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic                         pready,
   input wire logic [31:0]                  prdata,
   input wire logic                         pslverr,
   input wire logic                         ev_valid,
   input wire logic                         ev_ready,
   input wire logic                         mem_req_valid,
   input wire logic                         mem_req_ready,
   input wire logic [eqr_pkg::PTR_W-1:0]    mem_req_index,
   input wire eqr_pkg::eqr_rec_t            mem_req_rec,
   input wire logic                         mem_done,
   input wire logic                         mem_abort
);
   logic busy;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy <= 1'b0;
      end else if (mem_req_valid && mem_req_ready) begin
         busy <= 1'b1;
      end else if (mem_done || mem_abort) begin
         busy <= 1'b0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_req_hold: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid &&
      $stable(mem_req_index) && $stable(mem_req_rec)) else $error("write request not held");
   a_one_flight: assert property (busy |-> !mem_req_valid) else $error("second write in flight");
   a_pready_cause: assert property (psel && !penable |=> pready) else $error("no access answer");
   a_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_slverr_with: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_refused_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
   a_ready_fall: assert property ($fell(ev_ready) |-> $past(ev_valid)) else $error("buffer full uncaused");
   a_reset_idle: assert property (disable iff (1'b0) reset |-> !mem_req_valid && !pready && ev_ready)
      else $error("outputs active in reset");
endmodule
bind eqr_event_queue_recorder eqr_chk u_eqr_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ev_valid(ev_valid), .ev_ready(ev_ready),
   .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req_index(mem_req_index),
   .mem_req_rec(mem_req_rec), .mem_done(mem_done), .mem_abort(mem_abort));

/* File: tb/eqr_event_queue_recorder_bench.sv */
// Purpose: self-checking bench of the event queue recorder
// Assumes: ce held high, memory model answers at random pace
// Notes:   queue of four entries, wrap bit at bit 2
`timescale 1ns/1ps
module eqr_event_queue_recorder_bench;
   import eqr_pkg::*;
   logic             clk = 0, reset = 0, psel = 0, penable = 0, pwrite = 0, ev_valid = 0, abort_next = 0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0, prdata;
   logic             pready, pslverr, ev_ready, mem_req_valid, mem_req_ready, mem_done, mem_abort;
   logic [PTR_W-1:0] mem_req_index;
   eqr_rec_t         ev_rec = '0, mem_req_rec, ra, rb;
   logic [77:0]      mq[$];
   logic [32:0]      rq[$];
   int               err_total = 0, n_compared = 0, seed = 32'hB8D0, p = 0, i;
   always #4 clk = ~clk;
   eqr_event_queue_recorder u_eqr_event_queue_recorder (.clk(clk), .reset(reset), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .ev_valid(ev_valid), .ev_rec(ev_rec), .ev_ready(ev_ready), .mem_req_valid(mem_req_valid),
      .mem_req_ready(mem_req_ready), .mem_req_index(mem_req_index), .mem_req_rec(mem_req_rec),
      .mem_done(mem_done), .mem_abort(mem_abort));
   eqr_mem_model u_eqr_mem_model (.clk(clk), .reset(reset), .mem_req_valid(mem_req_valid),
      .abort_next(abort_next), .mem_req_ready(mem_req_ready), .mem_done(mem_done), .mem_abort(mem_abort));
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [77:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic lose;
      err_total++;
      wrap_up;
   endtask
   function automatic eqr_rec_t mk(input logic s, m);
      return {s, m, 56'({$random(seed), $random(seed)})};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 50) lose;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back({a > 8'h14, e});
      apb(0, a, 32'h0);
   endtask
   // wr: the record is expected at the next queue slot
   task automatic send(input eqr_rec_t r, input logic wr);
      int k;
      if (wr) mq.push_back({20'(p % 8), r});
      if (wr) p++;
      ev_valid <= 1;
      ev_rec <= r;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (ev_ready === 1'b1) break;
      end
      if (k == 50) lose;
      ev_valid <= 0;
      @(posedge clk);
   endtask
   task automatic settle;
      int k, q;
      q = 0;
      for (k = 0; k < 300 && q < 6; k++) begin
         @(posedge clk);
         q = (mem_req_valid !== 1'b0 || u_eqr_mem_model.busy) ? 0 : q + 1;
      end
      if (q < 6) lose;
   endtask
   always @(posedge clk) begin
      if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1) begin
         if (mq.size() == 0) chk(0, 1, "unexpected write");
         else chk({mem_req_index, mem_req_rec}, mq.pop_front(), "queue write");
      end
      if (psel && penable && !pwrite && pready === 1'b1) chk({pslverr, prdata}, rq.pop_front(), "read");
   end
   initial begin
      reset <= 1;
      repeat (12) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      for (i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
      send(mk(0, 0), 0);
      apb(1, OFS_CTRL, 32'h201);
      for (i = 0; i < 4; i++) send(mk(0, 0), 1);
      settle;
      rd(OFS_PRODUCER_INDEX_REGISTER, 32'h4);
      rd(OFS_STATUS, 32'h4);
      send(mk(0, 0), 0);
      send(mk(1, 0), 1);
      send(mk(1, 0), 1);
      settle;
      @(negedge clk);
      chk(ev_ready, 0, "ev_ready");
      @(posedge clk);
      rd(OFS_STATUS, 32'h24);
      rd(OFS_DROPS, 32'h2);
      apb(1, OFS_CONSUMER_INDEX_REGISTER, 32'h2);
      settle;
      rd(OFS_PRODUCER_INDEX_REGISTER, 32'h6);
      apb(1, OFS_CONSUMER_INDEX_REGISTER, 32'h6);
      ra = mk(0, 1);
      rb = mk(1, 1);
      send(ra, 1);
      send(ra, 0);
      send(rb, 1);
      send(rb, 1);
      settle;
      rd(OFS_MERGES, 32'h1);
      apb(1, OFS_CONSUMER_INDEX_REGISTER, 32'(p % 8));
      ra = mk(0, 0);
      send(ra, 1);
      send(ra, 1);
      settle;
      abort_next <= 1;
      send(mk(0, 0), 1);
      settle;
      p--;
      rd(OFS_PRODUCER_INDEX_REGISTER, 32'(p % 8));
      rd(OFS_STATUS, 32'h1);
      abort_next <= 0;
      send(mk(0, 0), 0);
      settle;
      rd(OFS_DROPS, 32'h3);
      wrap_up;
   end
endmodule
